// ===== rtl/acsp_pkg.sv
// constants and types for the converter control and serial port
// assumes a single 200 MHz master clock domain
`default_nettype none
package acsp_pkg;
    localparam int MCLK_PERIOD_NS = 5;
    // cal request must be seen high for more than four cycles
    localparam logic [2:0] CAL_MIN_CYC = 3'h5;
    localparam logic [2:0] LOAD_HOLD_CYC = 3'h4;
    localparam logic [4:0] WORD_BITS = 5'h10;
    localparam logic [4:0] AC_BITS = 5'h16;
    localparam logic [1:0] SSC_START_PH = 2'h3;
    localparam logic [1:0] SSC_LAST_PH = 2'h3;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 4;
    localparam logic [3:0] ADDR_STATUS = 4'h0;
    localparam logic [3:0] ADDR_MASK = 4'h1;
    localparam logic [3:0] ADDR_RESULT = 4'h2;
    localparam logic [3:0] ADDR_STATE = 4'h3;
    localparam int STATUS_W = 4;
    localparam int ST_LOADED = 0;
    localparam int ST_SENT = 1;
    localparam int ST_CALRST = 2;
    localparam int ST_CALGO = 3;
    localparam logic [3:0] STATUS_RST = 4'h0;
    localparam logic [3:0] MASK_RST = 4'h0;
    // synchronised pin vector layout
    localparam int PIN_PD_N = 0;
    localparam int PIN_POL = 1;
    localparam int PIN_CAL = 2;
    localparam int PIN_TA = 3;
    localparam int PIN_TB = 4;
    localparam int PIN_CS_N = 5;
    localparam int PIN_MODE = 6;
    localparam int PIN_SCLK = 8;
    localparam int PIN_W = 9;
    localparam logic [8:0] PIN_RST = 9'h021;
    typedef enum logic [1:0] {
        async_framed_mode = 2'b00,
        ext_clocked_sync_mode = 2'b01,
        self_clocked_sync_mode = 2'b10
    } acsp_mode_t;
    typedef enum logic [1:0] {
        tx_idle = 2'b00,
        tx_shift = 2'b01,
        tx_hold = 2'b10
    } acsp_tx_t;
endpackage
`default_nettype wire

// ===== rtl/acsp_sync.sv
// three-stage pin synchroniser with agreement filter
// assumes pins are asynchronous to clk_i
`timescale 1ns/1ps
`default_nettype none
module acsp_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] next_q;

    // accept a change once stages two and three agree
    always_comb begin
        next_q = (s2 & s3) | (q_o & (s2 ^ s3));
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s1 <= RST_VAL;
            s2 <= RST_VAL;
            s3 <= RST_VAL;
            q_o <= RST_VAL;
        end else begin
            s1 <= d_i;
            s2 <= s1;
            s3 <= s2;
            q_o <= next_q;
        end
    end
endmodule
`default_nettype wire

// ===== rtl/acsp_top.sv
// control pins, result word and serial port of a sigma-delta converter
// assumes the conversion core pulses result_load_i on mclk_i;
// pins and the serial clock are asynchronous and get synchronised here
// Notes on behaviour
// - power-down pin low puts the block in low power, stopping activity
// - polarity pin low selects unipolar range, high selects bipolar
// - cal request high over four clock cycles resets internal state
// - after a qualifying high, calibration starts when the request falls
// - cal request may be a shared strobe to keep converters in step
// - chip select low starts sending the word in the selected framing
// - word-valid goes low while a valid result sits in the output word
// - word-valid goes high once a word has been sent
// - loading a new result holds word-valid high for four cycles
// - serial clock pin direction follows the interface mode
// - self-clocked mode drives serial clock at mclk/4, 25% high
// - each result leaves the serial output as a 16-bit word
// - async mode: clock input, two bytes, one start, two stop bits
// - external sync mode: clock input, unframed, msb first
// - trim type pins sampled at cal rising edge pick calibration kind
`timescale 1ns/1ps
`default_nettype none
module acsp_top (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic power_down_n_i,
    input wire logic polarity_select_i,
    input wire logic cal_req_i,
    input wire logic trim_type_sel_a_i,
    input wire logic trim_type_sel_b_i,
    input wire logic cs_n_i,
    input wire logic [1:0] mode_i,
    input wire logic sclk_i,
    input wire logic [acsp_pkg::DATA_W-1:0] result_i,
    input wire logic result_load_i,
    input wire logic [acsp_pkg::ADDR_W-1:0] addr_i,
    input wire logic [acsp_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [acsp_pkg::DATA_W-1:0] rdata_o,
    output logic word_valid_n_o,
    output logic serial_out_o,
    output logic serial_out_oe_o,
    output logic sclk_o,
    output logic sclk_oe_o,
    output logic low_power_o,
    output logic bipolar_o,
    output logic cal_reset_o,
    output logic cal_start_o,
    output logic [1:0] cal_type_o,
    output logic irq_o
);
    import acsp_pkg::*;

    logic [PIN_W-1:0] sq;
    logic pd_n_s, pol_s, cal_s, cs_n_s, sclk_s;
    acsp_mode_t mode_s;

    acsp_sync #(.WIDTH(PIN_W), .RST_VAL(PIN_RST)) u_sync (
        .clk_i(mclk_i),
        .rst_i(rst_i),
        .d_i({sclk_i, mode_i, cs_n_i, trim_type_sel_b_i,
              trim_type_sel_a_i, cal_req_i, polarity_select_i,
              power_down_n_i}),
        .q_o(sq)
    );

    assign pd_n_s = sq[PIN_PD_N];
    assign pol_s = sq[PIN_POL];
    assign cal_s = sq[PIN_CAL];
    assign cs_n_s = sq[PIN_CS_N];
    assign sclk_s = sq[PIN_SCLK];
    assign mode_s = acsp_mode_t'(sq[PIN_MODE+1:PIN_MODE]);

    // power-down and polarity
    logic next_low_power, next_bipolar;
    always_comb begin
        next_low_power = !pd_n_s;
        next_bipolar = pol_s;
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            low_power_o <= 1'b0;
            bipolar_o <= 1'b0;
        end else begin
            low_power_o <= next_low_power;
            bipolar_o <= next_bipolar;
        end
    end

    // calibration request
    logic cal_q, cal_armed, cal_rst_ev;
    logic [2:0] cal_cnt;
    logic next_cal_q, next_cal_armed, next_cal_reset, next_cal_start;
    logic [2:0] next_cal_cnt;
    logic [1:0] next_cal_type;
    always_comb begin
        next_cal_q = cal_s;
        next_cal_cnt = cal_cnt;
        next_cal_armed = cal_armed;
        next_cal_type = cal_type_o;
        next_cal_start = 1'b0;
        cal_rst_ev = 1'b0;
        if (cal_s && !cal_q) begin
            next_cal_type = {sq[PIN_TB], sq[PIN_TA]};
        end
        if (cal_s) begin
            if (cal_cnt != CAL_MIN_CYC) begin
                next_cal_cnt = cal_cnt + 3'h1;
            end
            if (next_cal_cnt == CAL_MIN_CYC && !cal_armed) begin
                next_cal_armed = 1'b1;
                cal_rst_ev = 1'b1;
            end
        end else begin
            next_cal_cnt = 3'h0;
            if (cal_armed) begin
                next_cal_start = 1'b1;
                next_cal_armed = 1'b0;
            end
        end
        // shared strobe: every unit leaves reset on the same fall
        next_cal_reset = next_cal_armed && cal_s;
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            cal_q <= 1'b0;
            cal_cnt <= 3'h0;
            cal_armed <= 1'b0;
            cal_reset_o <= 1'b0;
            cal_start_o <= 1'b0;
            cal_type_o <= 2'h0;
        end else begin
            cal_q <= next_cal_q;
            cal_cnt <= next_cal_cnt;
            cal_armed <= next_cal_armed;
            cal_reset_o <= next_cal_reset;
            cal_start_o <= next_cal_start;
            cal_type_o <= next_cal_type;
        end
    end

    // output word and word-valid flag
    logic [DATA_W-1:0] out_word, next_out_word;
    logic [2:0] hold_cnt, next_hold_cnt;
    logic next_wvn, load_ok, load_ev, sent_ev;
    assign load_ok = result_load_i && !low_power_o && !cal_reset_o;
    always_comb begin
        next_out_word = out_word;
        next_hold_cnt = hold_cnt;
        next_wvn = word_valid_n_o;
        load_ev = 1'b0;
        if (cal_reset_o) begin
            next_wvn = 1'b1;
            next_hold_cnt = 3'h0;
        end else if (load_ok) begin
            next_out_word = result_i;
            next_hold_cnt = LOAD_HOLD_CYC;
            next_wvn = 1'b1;
            load_ev = 1'b1;
        end else if (hold_cnt != 3'h0) begin
            next_hold_cnt = hold_cnt - 3'h1;
            if (hold_cnt == 3'h1) begin
                next_wvn = 1'b0;
            end
        end else if (sent_ev) begin
            next_wvn = 1'b1;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            out_word <= 16'h0000;
            hold_cnt <= 3'h0;
            word_valid_n_o <= 1'b1;
        end else begin
            out_word <= next_out_word;
            hold_cnt <= next_hold_cnt;
            word_valid_n_o <= next_wvn;
        end
    end

    // serial transmitter
    acsp_tx_t state, next_state;
    logic [21:0] frame, next_frame;
    logic [4:0] bit_cnt, next_bit_cnt;
    logic [1:0] phase, next_phase;
    logic [DATA_W-1:0] rev_word;
    logic sclk_q, next_sclk_q, advance;
    logic next_so, next_oe, next_sclk, next_sclk_oe;

    always_comb begin
        for (int i = 0; i < DATA_W; i++) begin
            rev_word[i] = out_word[DATA_W-1-i];
        end
    end

    always_comb begin
        next_state = state;
        next_frame = frame;
        next_bit_cnt = bit_cnt;
        next_phase = phase;
        next_oe = serial_out_oe_o;
        next_sclk = 1'b0;
        next_sclk_q = sclk_s;
        sent_ev = 1'b0;
        next_sclk_oe = (mode_s == self_clocked_sync_mode);
        // self-clocked shifts as its own clock falls, others on pin fall
        if (mode_s == self_clocked_sync_mode) begin
            advance = (phase == 2'h0);
        end else begin
            advance = sclk_q && !sclk_s;
        end
        case (state)
            tx_idle: begin
                if (!cs_n_s && !word_valid_n_o && !low_power_o &&
                    !cal_reset_o) begin
                    next_state = tx_shift;
                    next_phase = SSC_START_PH;
                    next_oe = 1'b1;
                    if (mode_s == async_framed_mode) begin
                        // high byte first, each lsb first
                        next_frame = {2'b11, out_word[7:0], 1'b0,
                                      2'b11, out_word[15:8], 1'b0};
                        next_bit_cnt = AC_BITS;
                    end else begin
                        next_frame = {6'h3f, rev_word};
                        next_bit_cnt = WORD_BITS;
                    end
                end
            end
            tx_shift: begin
                next_phase = phase + 2'h1;
                next_sclk = (mode_s == self_clocked_sync_mode) &&
                            (phase == SSC_LAST_PH);
                if (advance) begin
                    next_frame = {1'b1, frame[21:1]};
                    next_bit_cnt = bit_cnt - 5'h01;
                    if (bit_cnt == 5'h01) begin
                        next_state = tx_hold;
                        next_oe = 1'b0;
                        sent_ev = 1'b1;
                    end
                end
            end
            tx_hold: begin
                next_oe = 1'b0;
            end
            default: begin
                next_state = tx_idle;
                next_oe = 1'b0;
            end
        endcase
        if (cs_n_s || next_low_power || cal_reset_o) begin
            next_state = tx_idle;
            next_oe = 1'b0;
            next_sclk = 1'b0;
        end
        next_so = next_frame[0];
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= tx_idle;
            frame <= 22'h3fffff;
            bit_cnt <= 5'h00;
            phase <= 2'h0;
            sclk_q <= 1'b0;
            serial_out_o <= 1'b1;
            serial_out_oe_o <= 1'b0;
            sclk_o <= 1'b0;
            sclk_oe_o <= 1'b0;
        end else begin
            state <= next_state;
            frame <= next_frame;
            bit_cnt <= next_bit_cnt;
            phase <= next_phase;
            sclk_q <= next_sclk_q;
            serial_out_o <= next_so;
            serial_out_oe_o <= next_oe;
            sclk_o <= next_sclk;
            sclk_oe_o <= next_sclk_oe;
        end
    end

    // register port and interrupt
    logic [STATUS_W-1:0] status, mask, ev, clr;
    logic [STATUS_W-1:0] next_status, next_mask;
    logic [DATA_W-1:0] next_rdata;
    logic next_irq;
    always_comb begin
        ev = '0;
        ev[ST_LOADED] = load_ev;
        ev[ST_SENT] = sent_ev;
        ev[ST_CALRST] = cal_rst_ev;
        ev[ST_CALGO] = next_cal_start;
        clr = '0;
        if (wr_i && addr_i == ADDR_STATUS) begin
            clr = wdata_i[STATUS_W-1:0];
        end
        // a new event beats a clear in the same cycle
        next_status = (status & ~clr) | ev;
        next_mask = mask;
        if (wr_i && addr_i == ADDR_MASK) begin
            next_mask = wdata_i[STATUS_W-1:0];
        end
        next_irq = |(next_status & next_mask);
        next_rdata = 16'h0000;
        if (rd_i) begin
            case (addr_i)
                ADDR_STATUS: next_rdata = {12'h000, status};
                ADDR_MASK: next_rdata = {12'h000, mask};
                ADDR_RESULT: next_rdata = out_word;
                ADDR_STATE: next_rdata = {6'h00, state, mode_s, cal_type_o,
                    cal_reset_o, low_power_o, bipolar_o, !word_valid_n_o};
                default: next_rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            status <= STATUS_RST;
            mask <= MASK_RST;
            irq_o <= 1'b0;
            rdata_o <= 16'h0000;
        end else begin
            status <= next_status;
            mask <= next_mask;
            irq_o <= next_irq;
            rdata_o <= next_rdata;
        end
    end

    // checks
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    low_power_quiet_a: assert property (
        low_power_o |-> !serial_out_oe_o && !sclk_o)
        else $error("activity while in low power");
    polarity_follow_a: assert property (
        $changed(bipolar_o) |-> bipolar_o == $past(pol_s))
        else $error("range select does not follow pin");
    cal_reset_a: assert property (
        (cal_s && !cal_reset_o)[*5] |=> cal_reset_o)
        else $error("no reset after long cal request");
    cal_start_a: assert property (
        (cal_reset_o && !cal_s) |=> cal_start_o ##1 !cal_start_o)
        else $error("calibration did not start on fall");
    cal_type_a: assert property (
        (cal_s && !cal_q) |=> cal_type_o == $past({sq[PIN_TB], sq[PIN_TA]}))
        else $error("calibration type not captured");
    tx_start_a: assert property (
        (state == tx_idle && !cs_n_s && !word_valid_n_o && !low_power_o
         && !cal_reset_o) |=> serial_out_oe_o && state == tx_shift)
        else $error("transmission not started");
    load_hold_a: assert property (
        load_ok |=> word_valid_n_o[*4])
        else $error("word-valid not held high after load");
    valid_low_a: assert property (
        (hold_cnt == 3'h1 && !load_ok && !cal_reset_o) |=> !word_valid_n_o)
        else $error("word-valid not low with valid word");
    word_sent_a: assert property (
        (sent_ev && hold_cnt == 3'h0 && !load_ok) |=> word_valid_n_o)
        else $error("word-valid not high after send");
    ssc_duty_a: assert property (
        $rose(sclk_o) |=> !sclk_o[*3])
        else $error("self clock not one high in four");
    sclk_dir_a: assert property (
        sclk_o |-> sclk_oe_o)
        else $error("serial clock driven while input");
    word_len_a: assert property (
        ($rose(serial_out_oe_o) && mode_s != async_framed_mode)
        |-> bit_cnt == WORD_BITS)
        else $error("sync word is not 16 bits");
    hiz_cs_a: assert property (
        cs_n_s |=> !serial_out_oe_o)
        else $error("serial output driven with chip select high");

    ssc_sent_c: cover property (sent_ev && mode_s == self_clocked_sync_mode);
    ac_sent_c: cover property (sent_ev && mode_s == async_framed_mode);
    cal_go_c: cover property (cal_start_o);
    load_c: cover property (load_ok ##5 !word_valid_n_o);
endmodule
`default_nettype wire

// ===== tb/acsp_partner.sv
// far-side serial receiver: owns chip select and the link clock
// assumes the bench calls rx_frame; link clock period 48 ns
`timescale 1ns/1ps
`default_nettype none
module acsp_partner (
    input wire logic mclk_i,
    input wire logic sd_i,
    input wire logic sd_oe_i,
    input wire logic sclk_in_i,
    output logic cs_n_o,
    output logic sclk_o
);
    logic last = 1'b0;
    logic line;
    // released line shows the inverse of the last driven bit
    assign line = sd_oe_i ? sd_i : ~last;
    always @(posedge mclk_i) begin
        if (sd_oe_i) begin
            last <= sd_i;
        end
    end
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
    end
    task automatic rx_frame(input logic self_clk, input int n,
                            input int slow_ns, output logic [21:0] bits);
        bits = '0;
        @(posedge mclk_i);
        cs_n_o <= 1'b0;
        if (self_clk) begin
            for (int i = 0; i < n; i++) begin
                @(posedge sclk_in_i);
                #1 bits[i] = line;
            end
        end else begin
            // clock stands low outside frames
            #103;
            for (int i = 0; i < n; i++) begin
                sclk_o = 1'b1;
                #24 bits[i] = line;
                sclk_o = 1'b0;
                #(24 + slow_ns);
            end
        end
        #200;
        @(posedge mclk_i);
        cs_n_o <= 1'b1;
    endtask
endmodule
`default_nettype wire

// ===== tb/adc_control_serial_port_tb_top.sv
// self-checking bench of the converter control and serial port
// assumes acsp_pkg, acsp_top and acsp_partner are compiled first
`timescale 1ns/1ps
`default_nettype none
`define chk(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
    $display("Error %s expected %h seen %h", nm, e, g); \
    error_cnt++; end end
module adc_control_serial_port_tb_top;
    import acsp_pkg::*;
    logic mclk_i, rst_i, power_down_n_i, polarity_select_i, cal_req_i;
    logic trim_type_sel_a_i, trim_type_sel_b_i, cs_n_i, sclk_i;
    logic [1:0] mode_i, cal_type_o;
    logic [15:0] result_i, wdata_i, rdata_o, d, w;
    logic [3:0] addr_i;
    logic result_load_i, wr_i, rd_i, word_valid_n_o, serial_out_o;
    logic serial_out_oe_o, sclk_o, sclk_oe_o, low_power_o, bipolar_o;
    logic cal_reset_o, cal_start_o, irq_o, prev_sclk;
    logic [21:0] bits;
    logic [15:0] exp_q[$];
    int error_cnt = 0, total_checks = 0;
    int gap = 0, gap_on = 0, hi_cnt = 0, len, rst_cnt, go_cnt;

    acsp_top acsp_top_inst (.mclk_i(mclk_i), .rst_i(rst_i),
        .power_down_n_i(power_down_n_i),
        .polarity_select_i(polarity_select_i), .cal_req_i(cal_req_i),
        .trim_type_sel_a_i(trim_type_sel_a_i),
        .trim_type_sel_b_i(trim_type_sel_b_i), .cs_n_i(cs_n_i),
        .mode_i(mode_i), .sclk_i(sclk_i), .result_i(result_i),
        .result_load_i(result_load_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .word_valid_n_o(word_valid_n_o), .serial_out_o(serial_out_o),
        .serial_out_oe_o(serial_out_oe_o), .sclk_o(sclk_o),
        .sclk_oe_o(sclk_oe_o), .low_power_o(low_power_o),
        .bipolar_o(bipolar_o), .cal_reset_o(cal_reset_o),
        .cal_start_o(cal_start_o), .cal_type_o(cal_type_o), .irq_o(irq_o));
    acsp_partner acsp_partner_inst (.mclk_i(mclk_i), .sd_i(serial_out_o),
        .sd_oe_i(serial_out_oe_o), .sclk_in_i(sclk_o), .cs_n_o(cs_n_i),
        .sclk_o(sclk_i));

    initial begin
        mclk_i = 1'b0;
        forever #2.5 mclk_i = ~mclk_i;
    end

    function automatic logic [21:0] frame_bits(input logic [1:0] m,
                                               input logic [15:0] v);
        logic [21:0] b;
        b = '0;
        if (m == 2'h0) begin
            b = {2'b11, v[7:0], 1'b0, 2'b11, v[15:8], 1'b0};
        end else begin
            for (int i = 0; i < 16; i++) b[i] = v[15-i];
        end
        return b;
    endfunction

    task automatic end_sim();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge mclk_i);
        addr_i <= a;
        wdata_i <= v;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [15:0] v);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1 v = rdata_o;
    endtask

    task automatic load_word(input logic [15:0] v, input int hold);
        @(posedge mclk_i);
        result_i <= v;
        result_load_i <= 1'b1;
        @(posedge mclk_i);
        result_load_i <= 1'b0;
        exp_q.delete();
        exp_q.push_back(v);
        for (int k = 0; k < hold; k++) begin
            #1 `chk("wvn hold", 1'b1, word_valid_n_o)
            @(posedge mclk_i);
        end
        #1 `chk("wvn ready", hold != 4, word_valid_n_o)
    endtask

    // cycle ceiling well above the expected run length
    initial begin
        repeat (30000) @(posedge mclk_i);
        error_cnt++;
        end_sim();
    end

    // self clock period and high time within frames
    always @(posedge mclk_i) begin
        prev_sclk <= sclk_o;
        if (sclk_o && !prev_sclk) begin
            if (gap_on) `chk("sclk period", 4, gap)
            gap = 1;
            gap_on = serial_out_oe_o;
        end else begin
            gap++;
        end
        if (!serial_out_oe_o) gap_on = 0;
        if (sclk_o && serial_out_oe_o) hi_cnt++;
    end

    initial begin
        rst_i = 1'b1;
        power_down_n_i = 1'b1;
        {polarity_select_i, cal_req_i, trim_type_sel_a_i} = '0;
        {trim_type_sel_b_i, result_load_i, wr_i, rd_i} = '0;
        mode_i = 2'h0;
        result_i = '0;
        wdata_i = '0;
        addr_i = '0;
        void'($urandom(32'h3fec6011));
        repeat (10) @(posedge mclk_i);
        rst_i <= 1'b0;
        #1 `chk("rst wvn", 1'b1, word_valid_n_o)
        `chk("rst oe", 1'b0, serial_out_oe_o)
        `chk("rst irq", 1'b0, irq_o)
        rd(ADDR_STATUS, d);
        `chk("rst status", 16'(STATUS_RST), d)
        rd(ADDR_MASK, d);
        `chk("rst mask", 16'(MASK_RST), d)
        for (int p = 0; p < 2; p++) begin
            @(posedge mclk_i);
            polarity_select_i <= p[0];
            power_down_n_i <= p[0];
            repeat (6) @(posedge mclk_i);
            #1 `chk("bipolar", p[0], bipolar_o)
            `chk("low power", ~p[0], low_power_o)
            if (p == 0) begin
                @(posedge mclk_i);
                result_load_i <= 1'b1;
                @(posedge mclk_i);
                result_load_i <= 1'b0;
                rd(ADDR_STATUS, d);
                `chk("load refused", 16'h0000, d)
            end
        end
        wr(ADDR_MASK, 16'h0002);
        w = 16'($urandom);
        load_word(w, 2);
        load_word(~w, 4);
        #1 `chk("irq masked", 1'b0, irq_o)
        rd(ADDR_RESULT, d);
        `chk("result", exp_q[0], d)
        wr(ADDR_MASK, 16'h000f);
        repeat (2) @(posedge mclk_i);
        #1 `chk("irq set", 1'b1, irq_o)
        wr(ADDR_STATUS, 16'h000f);
        repeat (2) @(posedge mclk_i);
        #1 `chk("irq clear", 1'b0, irq_o)
        rd(4'h7, d);
        `chk("unmapped", 16'h0000, d)
        wr(4'h7, 16'hffff);
        rd(ADDR_MASK, d);
        `chk("mask kept", 16'h000f, d)
        for (int m = 0; m < 3; m++) begin
            @(posedge mclk_i);
            mode_i <= m[1:0];
            repeat (8) @(posedge mclk_i);
            #1 `chk("sclk dir", m == 2, sclk_oe_o)
            load_word(16'($urandom), 4);
            hi_cnt = 0;
            acsp_partner_inst.rx_frame(m == 2, (m == 0) ? 22 : 16,
                                       0, bits);
            `chk("frame", frame_bits(m[1:0], exp_q[0]), bits)
            #1 `chk("wvn sent", 1'b1, word_valid_n_o)
            `chk("oe idle", 1'b0, serial_out_oe_o)
            if (m == 2) `chk("sclk highs", 16, hi_cnt)
            rd(ADDR_STATUS, d);
            `chk("sent flag", 1'b1, d[ST_SENT])
            wr(ADDR_STATUS, 16'h000f);
        end
        // valid word first, so the cal reset has to drop it
        load_word(w, 4);
        // calibration strobe, shared by converters in step
        for (int t = 0; t < 4; t++) begin
            len = (t == 3) ? 4 : 8;
            rst_cnt = 0;
            go_cnt = 0;
            @(posedge mclk_i);
            trim_type_sel_a_i <= t[0];
            trim_type_sel_b_i <= t[1];
            for (int k = 0; k < len + 16; k++) begin
                @(posedge mclk_i);
                cal_req_i <= (k < len);
                #1 rst_cnt += (cal_reset_o === 1'b1);
                go_cnt += (cal_start_o === 1'b1);
            end
            `chk("cal type", t[1:0], cal_type_o)
            `chk("cal reset", len - 4, rst_cnt)
            `chk("cal start", int'(len > 4), go_cnt)
            rd(ADDR_STATUS, d);
            `chk("cal flags", (len > 4) ? 2'b11 : 2'b00, d[3:2])
            wr(ADDR_STATUS, 16'h000f);
        end
        `chk("wvn cal", 1'b1, word_valid_n_o)
        // idle, self mode, type 3, bipolar, no valid word
        rd(ADDR_STATE, d);
        `chk("state", 16'h00b2, d)
        end_sim();
    end
endmodule
`default_nettype wire
